// [include/mfs_pkg.sv]
// Constants, encodings and register map of the fader strip message engine
// Behaviour
// - Thirty-two strips, each with mute, select, listen keys and a fader.
// - Mute key of strip n is note n minus 1 (0 to 31).
// - Select key of strip n is note 31 plus n (32 to 63).
// - Listen key of strip n is note 63 plus n (64 to 95).
// - Fader of strip n sends controller n minus 1 (0 to 31).
// - A key press sends note-on, then note-off for the same note.
// - Incoming messages of the same form drive the strip keys and faders.
// - Strip channel is main channel plus one; main channel 16 wraps to 1.
// - Default configuration sends strip messages on channel 2.
// - Transport buttons send machine-control transport messages to the all-call device id.
// - Fader law selects linear or audio taper mapping, both to a 7-bit controller value.
// - Channel and law changes take effect on apply; cancel discards them.
// - Soft controls send note, absolute CC, relative CC, machine-control or program change.
package mfs_pkg;
  localparam int STRIPS = 32;
  localparam int SOFTS  = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CHAN_PEND = 8'h00;
  localparam logic [7:0] OFS_LAW_PEND  = 8'h04;
  localparam logic [7:0] OFS_CTRL      = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_SOFT_BASE = 8'h40;
  // Field positions
  localparam int CTRL_APPLY_BIT  = 0;
  localparam int CTRL_CANCEL_BIT = 1;
  localparam int ST_LAW_BIT      = 4;
  localparam int ST_STRIP_LSB    = 8;
  localparam int ST_BUSY_BIT     = 16;
  localparam int SOFT_NUM_LSB    = 4;
  // Reset values: main channel code 0 is channel 1
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic       LAW_RST  = 1'b0;
  // Message encodings
  localparam logic [6:0] NOTE_MUTE_BASE   = 7'h00;
  localparam logic [6:0] NOTE_SEL_BASE    = 7'h20;
  localparam logic [6:0] NOTE_LISTEN_BASE = 7'h40;
  localparam logic [6:0] NOTE_LIMIT       = 7'h60;
  localparam logic [6:0] CC_FADER_BASE    = 7'h00;
  localparam logic [6:0] CC_FADER_LIMIT   = 7'h20;
  localparam logic [3:0] ST_NOTE_OFF = 4'h8;
  localparam logic [3:0] ST_NOTE_ON  = 4'h9;
  localparam logic [3:0] ST_CC       = 4'hB;
  localparam logic [3:0] ST_PROG     = 4'hC;
  localparam logic [7:0] VEL_ON      = 8'h7F;
  localparam logic [7:0] VEL_OFF     = 8'h00;
  localparam logic [6:0] REL_CENTRE  = 7'h40;
  localparam logic [7:0] SX_START    = 8'hF0;
  localparam logic [7:0] SX_RT       = 8'h7F;
  localparam logic [7:0] SX_ALL      = 8'h7F;
  localparam logic [7:0] SX_MMC_CMD  = 8'h06;
  localparam logic [7:0] SX_END      = 8'hF7;
  localparam logic [7:0] RT_FIRST    = 8'hF8;
  typedef enum logic [2:0] {
    EV_MUTE   = 3'b000,
    EV_SEL    = 3'b001,
    EV_LISTEN = 3'b010,
    EV_FADER  = 3'b011,
    EV_MMC    = 3'b100,
    EV_SOFT   = 3'b101
  } mfs_ev_t;
  typedef enum logic [2:0] {
    SOFT_NOTE   = 3'b000,
    SOFT_CC_ABS = 3'b001,
    SOFT_CC_REL = 3'b010,
    SOFT_MMC    = 3'b011,
    SOFT_PROG   = 3'b100
  } mfs_soft_t;
  typedef enum logic {
    LAW_LINEAR = 1'b0,
    LAW_AUDIO  = 1'b1
  } mfs_law_t;
endpackage

// [design/mfs_fader_law.sv]
// Fader position to 7-bit controller value and back, per fader law
`timescale 1ns/1ns
module mfs_fader_law (
  // Law select
  input  wire logic       law,
  // Position to value
  input  wire logic [9:0] posIn,
  output logic      [6:0] ccOut,
  // Value to position
  input  wire logic [6:0] ccIn,
  output logic      [9:0] posOut
);
  logic [10:0] upperFwd;
  logic [11:0] upperInv;
  always_comb begin
    upperFwd = 11'((posIn - 10'h200) * 3);
    upperInv = 12'((ccIn - 7'h20) * 21);
    if (law == mfs_pkg::LAW_LINEAR) begin
      ccOut  = posIn[9:3];
      posOut = {ccIn, ccIn[6:4]};
    end else begin
      // Lower half compressed, upper half finer, like the desk's own taper
      ccOut  = posIn[9] ? 7'(7'h20 + upperFwd[10:4]) : {2'b00, posIn[8:4]};
      posOut = (ccIn < 7'h20) ? {1'b0, ccIn[4:0], 4'h0} : 10'(10'h200 + upperInv[11:2]);
    end
  end
endmodule

// [design/mfs_strip_engine.sv]
// Fader strip, transport and soft control message encoder and decoder
`timescale 1ns/1ns
module mfs_strip_engine (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Local control events
  input  wire logic        evStrobe,
  input  wire logic [2:0]  evKind,
  input  wire logic [4:0]  evIndex,
  input  wire logic [9:0]  evValue,
  output logic             evBusy,
  // Outgoing message bytes
  output logic      [7:0]  txByte,
  output logic             txValid,
  input  wire logic        txReady,
  // Incoming message bytes
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  // Decoded incoming strip actions
  output logic             rxKeyStrobe,
  output logic      [1:0]  rxKeyKind,
  output logic      [4:0]  rxKeyIndex,
  output logic             rxFaderStrobe,
  output logic      [4:0]  rxFaderIndex,
  output logic      [9:0]  rxFaderPos
);
  logic [3:0]  pendChan;
  logic        pendLaw;
  logic [3:0]  activeChan;
  logic        activeLaw;
  logic [3:0]  stripChan;
  logic [10:0] softCfg [mfs_pkg::SOFTS];
  logic [7:0]  msg [6];
  logic [2:0]  msgLen;
  logic [2:0]  msgIdx;
  logic        pendOff;
  logic [7:0]  rxStat;
  logic        rxHaveD1;
  logic [6:0]  rxD1;
  logic [6:0]  ccFwd;
  logic [9:0]  posInv;
  logic        wrCtrl;
  logic        doApply;
  logic        doCancel;
  logic        evTake;
  logic        lastByte;
  logic [2:0]  softType;
  logic [6:0]  softNum;

  // Wraps naturally in four bits: main 16 gives strip channel 1
  assign stripChan = 4'(activeChan + 4'h1);
  assign wrCtrl    = regWr && regAddr == mfs_pkg::OFS_CTRL;
  assign doApply   = wrCtrl && regWdata[mfs_pkg::CTRL_APPLY_BIT];
  assign doCancel  = wrCtrl && regWdata[mfs_pkg::CTRL_CANCEL_BIT];
  assign evTake    = evStrobe && !evBusy;
  assign lastByte  = txValid && txReady && msgIdx == 3'(msgLen - 3'h1);
  assign softType  = softCfg[evIndex[3:0]][2:0];
  assign softNum   = softCfg[evIndex[3:0]][10:4];

  mfs_fader_law u_law (
    .law    (activeLaw),
    .posIn  (evValue),
    .ccOut  (ccFwd),
    .ccIn   (rxByte[6:0]),
    .posOut (posInv)
  );

  // Pending settings; cancel reloads them from the active copy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pendChan <= mfs_pkg::CHAN_RST;
      pendLaw  <= mfs_pkg::LAW_RST;
    end else if (doCancel && !doApply) begin
      pendChan <= activeChan;
      pendLaw  <= activeLaw;
    end else if (regWr && regAddr == mfs_pkg::OFS_CHAN_PEND) begin
      pendChan <= regWdata[3:0];
    end else if (regWr && regAddr == mfs_pkg::OFS_LAW_PEND) begin
      pendLaw <= regWdata[0];
    end
  end

  // Active settings change only on apply
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      activeChan <= mfs_pkg::CHAN_RST;
      activeLaw  <= mfs_pkg::LAW_RST;
    end else if (doApply) begin
      activeChan <= pendChan;
      activeLaw  <= pendLaw;
    end
  end

  // Soft control configuration, one word per control
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < mfs_pkg::SOFTS; i++) begin
        softCfg[i] <= '0;
      end
    end else if (regWr && regAddr[7:6] == mfs_pkg::OFS_SOFT_BASE[7:6]
                 && regAddr[1:0] == 2'b00) begin
      softCfg[regAddr[5:2]] <= {regWdata[10:4], 1'b0, regWdata[2:0]};
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= '0;
      if (regAddr == mfs_pkg::OFS_CHAN_PEND) begin
        regRdata[3:0] <= pendChan;
      end else if (regAddr == mfs_pkg::OFS_LAW_PEND) begin
        regRdata[0] <= pendLaw;
      end else if (regAddr == mfs_pkg::OFS_STATUS) begin
        regRdata[3:0] <= activeChan;
        regRdata[mfs_pkg::ST_LAW_BIT] <= activeLaw;
        regRdata[mfs_pkg::ST_STRIP_LSB +: 4] <= stripChan;
        regRdata[mfs_pkg::ST_BUSY_BIT] <= evBusy;
      end else if (regAddr[7:6] == mfs_pkg::OFS_SOFT_BASE[7:6] && regAddr[1:0] == 2'b00) begin
        regRdata[10:0] <= softCfg[regAddr[5:2]];
      end else begin
        regRdata <= '0;
      end
    end else begin
      regRdata <= '0;
    end
  end

  // Message builder: one event at a time, refused while busy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 6; i++) begin
        msg[i] <= '0;
      end
      msgLen  <= 3'h0;
      pendOff <= 1'b0;
    end else if (evTake) begin
      pendOff <= 1'b0;
      msgLen  <= 3'h3;
      msg[0]  <= {mfs_pkg::ST_NOTE_ON, stripChan};
      msg[2]  <= mfs_pkg::VEL_ON;
      unique case (evKind)
        mfs_pkg::EV_MUTE: begin
          msg[1]  <= {1'b0, 7'(mfs_pkg::NOTE_MUTE_BASE + evIndex)};
          pendOff <= 1'b1;
        end
        mfs_pkg::EV_SEL: begin
          msg[1]  <= {1'b0, 7'(mfs_pkg::NOTE_SEL_BASE + evIndex)};
          pendOff <= 1'b1;
        end
        mfs_pkg::EV_LISTEN: begin
          msg[1]  <= {1'b0, 7'(mfs_pkg::NOTE_LISTEN_BASE + evIndex)};
          pendOff <= 1'b1;
        end
        mfs_pkg::EV_FADER: begin
          msg[0] <= {mfs_pkg::ST_CC, stripChan};
          msg[1] <= {1'b0, 7'(mfs_pkg::CC_FADER_BASE + evIndex)};
          msg[2] <= {1'b0, ccFwd};
        end
        mfs_pkg::EV_MMC: begin
          // Device id all-call so every listener acts
          msg[0] <= mfs_pkg::SX_START;
          msg[1] <= mfs_pkg::SX_RT;
          msg[2] <= mfs_pkg::SX_ALL;
          msg[3] <= mfs_pkg::SX_MMC_CMD;
          msg[4] <= {1'b0, evValue[6:0]};
          msg[5] <= mfs_pkg::SX_END;
          msgLen <= 3'h6;
        end
        mfs_pkg::EV_SOFT: begin
          // Soft controls speak on the main channel, not the strip channel
          msg[0] <= {mfs_pkg::ST_CC, activeChan};
          msg[1] <= {1'b0, softNum};
          msg[2] <= {1'b0, evValue[6:0]};
          unique case (softType)
            mfs_pkg::SOFT_NOTE: begin
              msg[0]  <= {mfs_pkg::ST_NOTE_ON, activeChan};
              msg[2]  <= mfs_pkg::VEL_ON;
              pendOff <= 1'b1;
            end
            mfs_pkg::SOFT_CC_ABS: begin
              msg[2] <= {1'b0, evValue[6:0]};
            end
            mfs_pkg::SOFT_CC_REL: begin
              msg[2] <= {1'b0, 7'(mfs_pkg::REL_CENTRE + evValue[6:0])};
            end
            mfs_pkg::SOFT_MMC: begin
              msg[0] <= mfs_pkg::SX_START;
              msg[1] <= mfs_pkg::SX_RT;
              msg[2] <= mfs_pkg::SX_ALL;
              msg[3] <= mfs_pkg::SX_MMC_CMD;
              msg[4] <= {1'b0, softNum};
              msg[5] <= mfs_pkg::SX_END;
              msgLen <= 3'h6;
            end
            mfs_pkg::SOFT_PROG: begin
              msg[0] <= {mfs_pkg::ST_PROG, activeChan};
              msgLen <= 3'h2;
            end
            default: begin
              msgLen <= 3'h0;
            end
          endcase
        end
        default: begin
          msgLen <= 3'h0;
        end
      endcase
    end else if (lastByte && pendOff) begin
      // Same note again as a note-off
      msg[0]  <= {mfs_pkg::ST_NOTE_OFF, msg[0][3:0]};
      msg[2]  <= mfs_pkg::VEL_OFF;
      pendOff <= 1'b0;
    end
  end

  // Byte sender; a zero-length message only costs one busy cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evBusy  <= 1'b0;
      txValid <= 1'b0;
      txByte  <= '0;
      msgIdx  <= 3'h0;
    end else if (evTake) begin
      evBusy  <= 1'b1;
      msgIdx  <= 3'h0;
    end else if (evBusy && !txValid) begin
      txValid <= msgLen != 3'h0;
      evBusy  <= msgLen != 3'h0;
      txByte  <= msg[0];
    end else if (txValid && txReady) begin
      if (lastByte) begin
        msgIdx  <= 3'h0;
        txValid <= 1'b0;
        evBusy  <= pendOff;
      end else begin
        msgIdx <= 3'(msgIdx + 3'h1);
        txByte <= msg[3'(msgIdx + 3'h1)];
      end
    end
  end

  // Incoming parser with running status; real-time bytes pass through
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxStat   <= '0;
      rxHaveD1 <= 1'b0;
      rxD1     <= '0;
    end else if (rxValid && rxByte < mfs_pkg::RT_FIRST) begin
      if (rxByte[7]) begin
        rxStat   <= rxByte;
        rxHaveD1 <= 1'b0;
      end else if (!rxHaveD1) begin
        rxD1     <= rxByte[6:0];
        rxHaveD1 <= 1'b1;
      end else begin
        rxHaveD1 <= 1'b0;
      end
    end
  end

  // Strip actions from complete incoming messages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxKeyStrobe   <= 1'b0;
      rxKeyKind     <= '0;
      rxKeyIndex    <= '0;
      rxFaderStrobe <= 1'b0;
      rxFaderIndex  <= '0;
      rxFaderPos    <= '0;
    end else begin
      rxKeyStrobe   <= 1'b0;
      rxFaderStrobe <= 1'b0;
      if (rxValid && !rxByte[7] && rxHaveD1) begin
        // Note-off and zero-velocity note-on carry no press
        if (rxStat == {mfs_pkg::ST_NOTE_ON, stripChan} && rxByte != 8'h00
            && rxD1 < mfs_pkg::NOTE_LIMIT) begin
          rxKeyStrobe <= 1'b1;
          rxKeyKind   <= rxD1[6:5];
          rxKeyIndex  <= rxD1[4:0];
        end
        if (rxStat == {mfs_pkg::ST_CC, stripChan} && rxD1 < mfs_pkg::CC_FADER_LIMIT) begin
          rxFaderStrobe <= 1'b1;
          rxFaderIndex  <= rxD1[4:0];
          rxFaderPos    <= posInv;
        end
      end
    end
  end

  chk_strip_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    activeChan == 4'hF |-> stripChan == 4'h0)
    else $error("strip channel did not wrap");
  chk_apply_only: assert property (@(posedge clk) disable iff (!reset_n)
    !doApply |=> $stable(activeChan) && $stable(activeLaw))
    else $error("active setting changed without apply");
  chk_cancel_restore: assert property (@(posedge clk) disable iff (!reset_n)
    doCancel && !doApply |=> pendChan == $past(activeChan))
    else $error("cancel kept pending channel");
  chk_mute_note: assert property (@(posedge clk) disable iff (!reset_n)
    evTake && evKind == mfs_pkg::EV_MUTE |=> msg[1] == {3'b000, $past(evIndex)}
    && msg[0] == {mfs_pkg::ST_NOTE_ON, stripChan})
    else $error("mute note number wrong");
  chk_sel_note: assert property (@(posedge clk) disable iff (!reset_n)
    evTake && evKind == mfs_pkg::EV_SEL |=> msg[1] == {3'b001, $past(evIndex)})
    else $error("select note number wrong");
  chk_listen_note: assert property (@(posedge clk) disable iff (!reset_n)
    evTake && evKind == mfs_pkg::EV_LISTEN |=> msg[1] == {3'b010, $past(evIndex)})
    else $error("listen note number wrong");
  chk_fader_cc: assert property (@(posedge clk) disable iff (!reset_n)
    evTake && evKind == mfs_pkg::EV_FADER |=> msg[1] == {3'b000, $past(evIndex)}
    && msg[0][7:4] == mfs_pkg::ST_CC)
    else $error("fader controller number wrong");
  chk_note_off: assert property (@(posedge clk) disable iff (!reset_n)
    lastByte && pendOff |=> msg[0][7:4] == mfs_pkg::ST_NOTE_OFF && evBusy
    ##1 txValid && txByte == msg[0])
    else $error("note-off did not follow note-on");
  chk_mmc_all: assert property (@(posedge clk) disable iff (!reset_n)
    evTake && evKind == mfs_pkg::EV_MMC |=> msg[1] == mfs_pkg::SX_RT
    && msg[2] == mfs_pkg::SX_ALL && msgLen == 3'h6)
    else $error("transport message not all-call");
  chk_rx_key: assert property (@(posedge clk) disable iff (!reset_n)
    rxValid && rxHaveD1 && !rxByte[7] && rxByte != 8'h00 && rxD1 < mfs_pkg::NOTE_LIMIT
    && rxStat == {mfs_pkg::ST_NOTE_ON, stripChan} |=> rxKeyStrobe && rxKeyIndex == $past(rxD1[4:0]))
    else $error("incoming key not applied");
endmodule

// [testbench/mfs_link_model.sv]
// Far-side link model: sinks outgoing message bytes, with optional stalls
`timescale 1ns/1ns
module mfs_link_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Outgoing byte stream
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  output logic            txReady,
  // Stall control
  input  wire logic       slow
);
  logic [7:0] seen [$];
  logic [1:0] phase;
  // Slow mode accepts one cycle in four, like a busy host
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase   <= 2'h0;
      txReady <= 1'b0;
    end else begin
      phase   <= phase + 2'h1;
      txReady <= !slow || (phase == 2'h3);
    end
  end
  // Bench reads and clears the capture between events
  always @(posedge clk) begin
    if (reset_n && txValid && txReady) begin
      seen.push_back(txByte);
    end
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the fader strip message engine
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  logic        evStrobe = 1'b0;
  logic [2:0]  evKind = 3'h0;
  logic [4:0]  evIndex = 5'h00;
  logic [9:0]  evValue = 10'h000;
  logic        evBusy;
  logic [7:0]  txByte;
  logic        txValid;
  logic        txReady;
  logic [7:0]  rxByte = 8'h00;
  logic        rxValid = 1'b0;
  logic        rxKeyStrobe;
  logic [1:0]  rxKeyKind;
  logic [4:0]  rxKeyIndex;
  logic        rxFaderStrobe;
  logic [4:0]  rxFaderIndex;
  logic [9:0]  rxFaderPos;
  logic        slow = 1'b0;
  logic [7:0]  expq [$];
  logic [31:0] rdv;
  logic [7:0]  n;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  mfs_strip_engine DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .evStrobe(evStrobe), .evKind(evKind),
    .evIndex(evIndex), .evValue(evValue), .evBusy(evBusy), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .rxByte(rxByte), .rxValid(rxValid), .rxKeyStrobe(rxKeyStrobe),
    .rxKeyKind(rxKeyKind), .rxKeyIndex(rxKeyIndex), .rxFaderStrobe(rxFaderStrobe),
    .rxFaderIndex(rxFaderIndex), .rxFaderPos(rxFaderPos));

  mfs_link_model link (.clk(clk), .reset_n(reset_n), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .slow(slow));

  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask

  // Poke raises a second request while the first is still going out
  task automatic ev(input logic [2:0] k, input logic [4:0] i, input logic [9:0] v,
                    input bit poke);
    int j;
    link.seen.delete();
    @(posedge clk);
    evKind   <= k;
    evIndex  <= i;
    evValue  <= v;
    evStrobe <= 1'b1;
    for (j = 0; j < 400; j++) begin
      @(posedge clk);
      evStrobe <= poke && (j == 2);
      #1;
      if (j > 0 && evBusy !== 1'b1) break;
    end
    if (j == 400) chk(32'h1, 32'h0);
    @(posedge clk);
  endtask

  task automatic msgchk();
    chk(link.seen.size(), expq.size());
    foreach (expq[k]) begin
      if (k < link.seen.size()) chk(link.seen[k], expq[k]);
    end
  endtask

  task automatic rx3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clk);
    rxByte  <= a;
    rxValid <= 1'b1;
    @(posedge clk);
    rxByte <= b;
    @(posedge clk);
    rxByte <= c;
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte  <= ~c;
    #1;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h0C);
    chk(rdv, 32'h0000_0100);
    rd(8'h20);
    chk(rdv, 32'h0);
    rx3(8'h91, 8'h05, 8'h40);
    chk({rxKeyStrobe, rxKeyKind, rxKeyIndex}, {1'b1, 2'h0, 5'h05});
    rx3(8'h91, 8'h3F, 8'h01);
    chk({rxKeyStrobe, rxKeyKind, rxKeyIndex}, {1'b1, 2'h1, 5'h1F});
    rx3(8'h91, 8'h45, 8'h7F);
    chk({rxKeyStrobe, rxKeyKind, rxKeyIndex}, {1'b1, 2'h2, 5'h05});
    rx3(8'hB1, 8'h1F, 8'h7F);
    chk({rxFaderStrobe, rxFaderIndex, rxFaderPos}, {1'b1, 5'h1F, 10'h3FF});
    rx3(8'h92, 8'h05, 8'h40);
    chk(rxKeyStrobe, 1'b0);
    rx3(8'h91, 8'h05, 8'h00);
    chk(rxKeyStrobe, 1'b0);
    // Notes above the listen range and controllers above the faders are not strip actions
    rx3(8'h91, 8'h60, 8'h7F);
    chk(rxKeyStrobe, 1'b0);
    rx3(8'hB1, 8'h20, 8'h10);
    chk(rxFaderStrobe, 1'b0);
    // Key kinds, mute and select at the strip range edges, listen at index 4 with a stalling host
    for (int t = 0; t < 3; t++) begin
      slow = (t == 2);
      n = 8'(t * 32 + (t == 1 ? 31 : t * 2));
      ev(3'(t), 5'(n % 32), 10'h000, 1'b0);
      expq = '{8'h91, n, 8'h7F, 8'h81, n, 8'h00};
      msgchk();
    end
    ev(3'h3, 5'h1F, 10'h3FF, 1'b1);
    expq = '{8'hB1, 8'h1F, 8'h7F};
    msgchk();
    slow = 1'b0;
    wr(8'h00, 32'hF);
    wr(8'h04, 32'h1);
    rd(8'h0C);
    chk(rdv, 32'h0000_0100);
    rd(8'h00);
    chk(rdv, 32'h0000_000F);
    rd(8'h04);
    chk(rdv, 32'h0000_0001);
    wr(8'h08, 32'h2);
    rd(8'h0C);
    chk(rdv, 32'h0000_0100);
    rd(8'h00);
    chk(rdv, 32'h0);
    rd(8'h04);
    chk(rdv, 32'h0);
    wr(8'h00, 32'hF);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h1);
    rd(8'h0C);
    chk(rdv, 32'h0000_001F);
    ev(3'h0, 5'h02, 10'h000, 1'b0);
    expq = '{8'h90, 8'h02, 8'h7F, 8'h80, 8'h02, 8'h00};
    msgchk();
    ev(3'h3, 5'h00, 10'h100, 1'b0);
    expq = '{8'hB0, 8'h00, 8'h10};
    msgchk();
    ev(3'h4, 5'h00, 10'h002, 1'b0);
    expq = '{8'hF0, 8'h7F, 8'h7F, 8'h06, 8'h02, 8'hF7};
    msgchk();
    rx3(8'h90, 8'h07, 8'h7F);
    chk({rxKeyStrobe, rxKeyKind, rxKeyIndex}, {1'b1, 2'h0, 5'h07});
    // Upper half of the audio taper on the way in
    rx3(8'hB0, 8'h05, 8'h40);
    chk({rxFaderStrobe, rxFaderIndex, rxFaderPos}, {1'b1, 5'h05, 10'h2A8});
    // Every soft control type, on the main channel (code F here); type 5 sends nothing
    for (int t = 0; t < 6; t++) begin
      n = 8'h10 + 8'(t);
      wr(8'h40 + 8'(4 * t), 32'(n) << 4 | 32'(t));
      ev(3'h5, 5'(t), 10'h003, 1'b0);
      case (t)
        0: expq = '{8'h9F, n, 8'h7F, 8'h8F, n, 8'h00};
        1: expq = '{8'hBF, n, 8'h03};
        2: expq = '{8'hBF, n, 8'h43};
        3: expq = '{8'hF0, 8'h7F, 8'h7F, 8'h06, n, 8'hF7};
        4: expq = '{8'hCF, n};
        default: expq.delete();
      endcase
      msgchk();
    end
    wrap_up();
  end
endmodule
